// File: design/line_thermal_fn.sv
/*
 Line thermal replica: per-phase windowed mean square, maximum selection,
 first-order thermal model, threshold decisions and status outputs.
 Assumes one 1 kHz sample strobe, samples at least 200 clocks apart,
 and a register master that follows the plain port protocol.
*/
`timescale 1ns/1ps
`include "line_thermal_regs.svh"

module line_thermal_fn
    import line_thermal_pkg::*;
#(
    parameter int          WIN_LOG2    = 5,
    parameter logic [15:0] NOM_CURRENT = 16'h1000
) (
    // Clock and reset
    input  wire logic               core_clk,
    input  wire logic               rst_n,
    // Register port
    input  wire logic [3:0]         addr,
    input  wire logic [15:0]        wr_data,
    input  wire logic               wr_en,
    input  wire logic               rd_en,
    output logic      [15:0]        rd_data,
    // Phase current samples
    input  wire logic               sample_valid,
    input  wire logic signed [15:0] phase1_current,
    input  wire logic signed [15:0] phase2_current,
    input  wire logic signed [15:0] phase3_current,
    input  wire logic signed [7:0]  ambient_sensor_temp,
    // Binary inputs
    input  wire logic               disable_in,
    input  wire logic               heat_reset_in,
    // Status outputs
    output logic                    alarm_out,
    output logic                    general_trip_out,
    output logic                    reclose_block_out,
    output logic      [15:0]        calc_temperature_value
);
    localparam int WIN  = 1 << WIN_LOG2;
    localparam int SUMW = 32 + WIN_LOG2;
    localparam int F    = `FRAC_BITS;

    // Settings
    logic [1:0]  mode_ff;
    logic        sens_ff;
    logic [7:0]  alarm_ff, trip_ff, rated_ff, base_ff, unlock_ff;
    logic [7:0]  amb_ff, start_ff, load_ff;
    logic [9:0]  tc_ff;
    logic [15:0] pulse_len_ff;
    // Calculation state
    calc_state_e            state_ff;
    logic signed [15:0]     hist_ff [3][WIN];
    logic [WIN_LOG2-1:0]    wp_ff;
    logic [SUMW-1:0]        sum_ff [3];
    logic [63:0]            q_ff;
    logic                   init_ff;
    logic                   step_neg_ff;
    logic [32:0]            rem_ff;
    logic [`DIV_W-1:0]      quo_ff;
    logic [31:0]            den_ff;
    logic [6:0]             cnt_ff;
    logic                   above_alm_ff, above_trip_ff, above_unl_ff;
    logic                   arm_ff, lock_ff, block_ff;
    logic [15:0]            pulse_cnt_ff;
    logic                   alarm_out_ff, general_trip_out_ff, reclose_block_out_ff;
    logic [15:0]            calc_temperature_value_ff, rd_data_ff;

    function automatic logic [15:0] clamp(input logic [15:0] v, lo, hi);
        clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    function automatic logic [31:0] sq(input logic signed [15:0] x);
        logic signed [31:0] p;
        p = 32'(x) * 32'(x);
        sq = unsigned'(p);
    endfunction

    // Phase inputs as an array for the window loop
    logic signed [15:0] smp_w [3];
    assign smp_w[0] = phase1_current;
    assign smp_w[1] = phase2_current;
    assign smp_w[2] = phase3_current;

    // Maximum of mean squares; ordering equals ordering of RMS values
    wire [SUMW-1:0] max12_w  = (sum_ff[0] > sum_ff[1]) ? sum_ff[0] : sum_ff[1];
    wire [SUMW-1:0] max_sum_w = (max12_w > sum_ff[2]) ? max12_w : sum_ff[2];
    wire [31:0]     mean_sq_w = 32'(max_sum_w >> WIN_LOG2);

    // Scaled rated current, its square and the rated rise
    wire [15:0] in_code_w = 16'((24'(load_ff) * 24'(NOM_CURRENT)) / 24'(`PCT_DIV));
    wire [31:0] in_sq_w   = 32'(in_code_w) * 32'(in_code_w);
    wire [7:0]  rise_w    = rated_ff - base_ff;
    wire [31:0] tsteps_w  = 32'(tc_ff) * 32'(`SEC_PER_MIN) * 32'(`SAMPLE_RATE_HZ);
    wire [63:0] startup_q_w =
        64'(((72'(start_ff) * 72'(in_sq_w)) << F) / 72'(`PCT_DIV));
    wire signed [8:0] amb_w =
        sens_ff ? {ambient_sensor_temp[7], ambient_sensor_temp} : {1'b0, amb_ff};

    // State held as level times In^2, so the step needs one division by T/dt
    wire [63:0] target_w   = {mean_sq_w, 32'h0000_0000};
    wire        tgt_ge_w   = target_w >= q_ff;
    wire [63:0] step_mag_w = tgt_ge_w ? target_w - q_ff : q_ff - target_w;
    wire [63:0] q_step_w   = step_neg_ff ? q_ff - quo_ff[63:0] : q_ff + quo_ff[63:0];
    wire [`DIV_W-1:0] temp_num_w =
        (72'(q_step_w) * 72'(rise_w)) >> (F - `TEMP_FRAC);

    // Shared restoring divider, one quotient bit per clock
    wire              div_load_w = (state_ff == ST_LOAD_STEP) || (state_ff == ST_APPLY);
    wire [`DIV_W-1:0] div_num_w  = (state_ff == ST_LOAD_STEP) ? 72'(step_mag_w) : temp_num_w;
    wire [31:0]       div_den_w  = (state_ff == ST_LOAD_STEP) ? tsteps_w : in_sq_w;
    wire [32:0]       rem_sh_w   = {rem_ff[31:0], quo_ff[`DIV_W-1]};
    wire              rem_ge_w   = rem_sh_w >= {1'b0, den_ff};
    wire              div_done_w = cnt_ff == 7'h00;

    // Temperature: rise in 1/16 degree plus ambient, saturated to 16 bits
    wire [16:0] t_rise_w = (|quo_ff[`DIV_W-1:16]) ? 17'h0FFFF : {1'b0, quo_ff[15:0]};
    // Widen before the shift: 40 degrees in 1/16 steps overflows nine bits
    wire signed [18:0] t_tot_w = $signed({2'b00, t_rise_w}) + (19'(amb_w) <<< `TEMP_FRAC);
    wire [15:0] t_sat_w = t_tot_w[18] ? 16'h0000 : (t_tot_w[17:16] != 2'b00) ?
                          16'hFFFF : t_tot_w[15:0];

    // Comparisons in heat units avoid a division: q*rise > (thr-amb)*In^2*2^F
    wire signed [81:0] heat_w = $signed({10'b0, 72'(q_ff) * 72'(rise_w)});
    // All operands are arguments, so each assignment tracks every one of them
    function automatic logic exceeds(input logic [7:0] thr, input logic signed [81:0] heat,
                                     input logic signed [8:0] amb, input logic [31:0] in_sq);
        logic signed [9:0]  d;
        logic signed [81:0] lim;
        d   = $signed({2'b00, thr}) - 10'(amb);
        lim = (82'(d) * $signed({50'b0, in_sq})) <<< F;
        exceeds = heat > lim;
    endfunction
    wire alm_hit_w  = exceeds(alarm_ff, heat_w, amb_w, in_sq_w);
    wire trip_hit_w = exceeds(trip_ff, heat_w, amb_w, in_sq_w);
    wire unl_hit_w  = exceeds(unlock_ff, heat_w, amb_w, in_sq_w);

    // Mode and block decode
    wire mode_ok_w = (mode_ff == `MODE_PULSED) || (mode_ff == `MODE_LOCKED);
    wire en_w      = mode_ok_w && !disable_in;
    wire trip_w    = (mode_ff == `MODE_PULSED) ? (pulse_cnt_ff != 16'h0000) : lock_ff;
    wire restart_w = init_ff || heat_reset_in;

    // Register writes, clamped to the accepted ranges
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            mode_ff <= `MODE_PULSED;
            sens_ff <= 1'b0;
            alarm_ff <= `RST_ALARM;
            trip_ff <= `RST_TRIP;
            rated_ff <= `RST_RATED;
            base_ff <= `RST_BASE;
            unlock_ff <= `RST_UNLOCK;
            amb_ff <= `RST_AMBIENT;
            start_ff <= `RST_STARTUP;
            load_ff <= `RST_LOAD;
            tc_ff <= `RST_TCONST;
            pulse_len_ff <= `RST_PULSE;
        end else if (wr_en) begin
            case (addr)
                `ADDR_CTRL: begin
                    mode_ff <= wr_data[`CTRL_MODE_MSB:0];
                    sens_ff <= wr_data[`CTRL_SENS_BIT];
                end
                `ADDR_ALARM:   alarm_ff  <= 8'(clamp(wr_data, `LIM_TEMP_MIN, `LIM_TEMP_MAX));
                `ADDR_TRIP:    trip_ff   <= 8'(clamp(wr_data, `LIM_TEMP_MIN, `LIM_TEMP_MAX));
                `ADDR_RATED:   rated_ff  <= 8'(clamp(wr_data, `LIM_TEMP_MIN, `LIM_TEMP_MAX));
                `ADDR_BASE:    base_ff   <= 8'(clamp(wr_data, `LIM_ZERO, `LIM_LOW_MAX));
                `ADDR_UNLOCK:  unlock_ff <= 8'(clamp(wr_data, `LIM_UNL_MIN, `LIM_TEMP_MAX));
                `ADDR_AMBIENT: amb_ff    <= 8'(clamp(wr_data, `LIM_ZERO, `LIM_LOW_MAX));
                `ADDR_STARTUP: start_ff  <= 8'(clamp(wr_data, `LIM_ZERO, `LIM_START_MAX));
                `ADDR_LOAD:    load_ff   <= 8'(clamp(wr_data, `LIM_LOAD_MIN, `LIM_LOAD_MAX));
                `ADDR_TCONST:  tc_ff     <= 10'(clamp(wr_data, `LIM_TC_MIN, `LIM_TC_MAX));
                `ADDR_PULSE:   pulse_len_ff <= clamp(wr_data, `LIM_PULSE_MIN, `LIM_PULSE_MAX);
                default: ;
            endcase
        end
    end

    // Sliding window of squares per phase, updated on every sample
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wp_ff <= '0;
            for (int p = 0; p < 3; p++) begin
                sum_ff[p] <= '0;
                for (int i = 0; i < WIN; i++) hist_ff[p][i] <= '0;
            end
        end else if (sample_valid) begin
            wp_ff <= wp_ff + 1'b1;
            for (int p = 0; p < 3; p++) begin
                hist_ff[p][wp_ff] <= smp_w[p];
                sum_ff[p] <= sum_ff[p] + SUMW'(sq(smp_w[p])) - SUMW'(sq(hist_ff[p][wp_ff]));
            end
        end
    end

    // Step sequencer; a heat reset aborts any step in flight
    always_ff @(posedge core_clk) begin
        if (!rst_n || restart_w) begin
            state_ff <= ST_IDLE;
        end else begin
            case (state_ff)
                ST_IDLE:      state_ff <= sample_valid ? ST_LOAD_STEP : ST_IDLE;
                ST_LOAD_STEP: state_ff <= ST_DIV_STEP;
                ST_DIV_STEP:  state_ff <= div_done_w ? ST_APPLY : ST_DIV_STEP;
                ST_APPLY:     state_ff <= ST_DIV_TEMP;
                ST_DIV_TEMP:  state_ff <= div_done_w ? ST_DECIDE : ST_DIV_TEMP;
                ST_DECIDE:    state_ff <= ST_IDLE;
                default:      state_ff <= ST_IDLE;
            endcase
        end
    end

    // Thermal state; the first cycle after reset loads the startup value
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            q_ff <= '0;
            init_ff <= 1'b1;
            step_neg_ff <= 1'b0;
        end else begin
            init_ff <= 1'b0;
            if (restart_w) q_ff <= startup_q_w;
            else if (state_ff == ST_APPLY) q_ff <= q_step_w;
            if (state_ff == ST_LOAD_STEP) step_neg_ff <= !tgt_ge_w;
        end
    end

    // Divider registers
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rem_ff <= '0;
            quo_ff <= '0;
            den_ff <= '0;
            cnt_ff <= '0;
        end else if (div_load_w) begin
            rem_ff <= '0;
            quo_ff <= div_num_w;
            den_ff <= div_den_w;
            cnt_ff <= `DIV_CNT_INIT;
        end else if (!div_done_w) begin
            rem_ff <= rem_ge_w ? rem_sh_w - {1'b0, den_ff} : rem_sh_w;
            quo_ff <= {quo_ff[`DIV_W-2:0], rem_ge_w};
            cnt_ff <= cnt_ff - 1'b1;
        end
    end

    // Threshold flags and published temperature, once per step
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            above_alm_ff <= 1'b0;
            above_trip_ff <= 1'b0;
            above_unl_ff <= 1'b0;
            calc_temperature_value_ff <= '0;
        end else if (state_ff == ST_DECIDE) begin
            above_alm_ff <= alm_hit_w;
            above_trip_ff <= trip_hit_w;
            above_unl_ff <= unl_hit_w;
            calc_temperature_value_ff <= t_sat_w;
        end
    end

    // Trip pulse, lock and reclose block; cleared while disabled or off
    always_ff @(posedge core_clk) begin
        if (!rst_n || !en_w) begin
            pulse_cnt_ff <= '0;
            arm_ff <= 1'b1;
            lock_ff <= 1'b0;
            block_ff <= 1'b0;
        end else if (state_ff == ST_DECIDE) begin
            if (mode_ff == `MODE_PULSED) begin
                if (trip_hit_w && arm_ff) begin
                    pulse_cnt_ff <= pulse_len_ff;
                    arm_ff <= 1'b0;
                end else if (pulse_cnt_ff != 16'h0000) begin
                    pulse_cnt_ff <= pulse_cnt_ff - 16'h0001;
                end
                if (!trip_hit_w) arm_ff <= 1'b1;
            end
            lock_ff <= (mode_ff == `MODE_LOCKED) && (trip_hit_w || (lock_ff && unl_hit_w));
            block_ff <= trip_hit_w || (pulse_cnt_ff > 16'h0001) || (block_ff && unl_hit_w);
        end
    end

    // Registered outputs and read data, valid only the cycle after a read
    logic [15:0] rd_mux_w;
    always_comb begin
        case (addr)
            `ADDR_CTRL:    rd_mux_w = {13'h0000, sens_ff, mode_ff};
            `ADDR_ALARM:   rd_mux_w = {8'h00, alarm_ff};
            `ADDR_TRIP:    rd_mux_w = {8'h00, trip_ff};
            `ADDR_RATED:   rd_mux_w = {8'h00, rated_ff};
            `ADDR_BASE:    rd_mux_w = {8'h00, base_ff};
            `ADDR_UNLOCK:  rd_mux_w = {8'h00, unlock_ff};
            `ADDR_AMBIENT: rd_mux_w = {8'h00, amb_ff};
            `ADDR_STARTUP: rd_mux_w = {8'h00, start_ff};
            `ADDR_LOAD:    rd_mux_w = {8'h00, load_ff};
            `ADDR_TCONST:  rd_mux_w = {6'h00, tc_ff};
            `ADDR_PULSE:   rd_mux_w = pulse_len_ff;
            `ADDR_TEMP:    rd_mux_w = calc_temperature_value_ff;
            `ADDR_STATUS:  rd_mux_w = {10'h000, reclose_block_out_ff, general_trip_out_ff,
                                       alarm_out_ff, above_unl_ff, above_trip_ff, above_alm_ff};
            default:       rd_mux_w = 16'h0000;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            alarm_out_ff <= 1'b0;
            general_trip_out_ff <= 1'b0;
            reclose_block_out_ff <= 1'b0;
            rd_data_ff <= '0;
        end else begin
            alarm_out_ff <= en_w && above_alm_ff;
            general_trip_out_ff <= en_w && trip_w;
            reclose_block_out_ff <= en_w && block_ff;
            rd_data_ff <= rd_en ? rd_mux_w : 16'h0000;
        end
    end

    assign alarm_out = alarm_out_ff;
    assign general_trip_out = general_trip_out_ff;
    assign reclose_block_out = reclose_block_out_ff;
    assign calc_temperature_value = calc_temperature_value_ff;
    assign rd_data = rd_data_ff;

    // Checks on the decision path
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    off_quiet_a: assert property (
        !mode_ok_w |=> !alarm_out_ff && !general_trip_out_ff && !reclose_block_out_ff)
        else $error("status output active in off mode");
    block_quiet_a: assert property (
        disable_in |=> !alarm_out_ff && !general_trip_out_ff && !reclose_block_out_ff)
        else $error("status output active while blocked");
    block_follow_a: assert property (
        general_trip_out_ff |-> reclose_block_out_ff)
        else $error("trip without reclose block");
    lock_hold_a: assert property (
        $fell(general_trip_out_ff) && mode_ff == `MODE_LOCKED && $stable(mode_ff)
        && $past(en_w) |-> !above_unl_ff)
        else $error("locked trip released above unlock");
    pulse_start_a: assert property (
        state_ff == ST_DECIDE && en_w && mode_ff == `MODE_PULSED && trip_hit_w && arm_ff
        && !disable_in ##1 en_w |-> pulse_cnt_ff == $past(pulse_len_ff) ##1 general_trip_out_ff)
        else $error("trip pulse not started");
    rearm_a: assert property (
        $rose(arm_ff) && $past(en_w) |-> !above_trip_ff)
        else $error("pulse rearmed above trip");
    alarm_cmp_a: assert property (
        alarm_out_ff |-> $past(above_alm_ff) && $past(en_w))
        else $error("alarm without threshold");
    max_sel_a: assert property (
        max_sum_w >= sum_ff[0] && max_sum_w >= sum_ff[1] && max_sum_w >= sum_ff[2])
        else $error("maximum selection wrong");
    heat_rst_a: assert property (
        heat_reset_in |=> q_ff == $past(startup_q_w) && state_ff == ST_IDLE)
        else $error("heat reset not applied");
    set_range_a: assert property (
        trip_ff >= 8'(`LIM_TEMP_MIN) && trip_ff <= 8'(`LIM_TEMP_MAX) && base_ff <= 8'(`LIM_LOW_MAX))
        else $error("setting out of range");
    step_dir_a: assert property (
        state_ff == ST_APPLY && !step_neg_ff && !restart_w |=> q_ff >= $past(q_ff))
        else $error("heating step lowered state");
    temp_pub_a: assert property (
        $changed(calc_temperature_value_ff) |-> $past(state_ff) == ST_DECIDE)
        else $error("temperature changed outside step");

    pulse_seen_c: cover property (mode_ff == `MODE_PULSED && $rose(general_trip_out_ff));
    lock_rel_c: cover property (mode_ff == `MODE_LOCKED && $fell(general_trip_out_ff));
    alarm_seen_c: cover property ($rose(alarm_out_ff));
    heat_rst_c: cover property (heat_reset_in && q_ff != 64'h0);

endmodule // line_thermal_fn

// File: common/line_thermal_regs.svh
/*
 Register offsets, field positions, reset values, setting limits and
 arithmetic constants of the line thermal replica.
 Assumes a 4-bit word address on a plain register port.
*/
`ifndef LINE_THERMAL_REGS_SVH
`define LINE_THERMAL_REGS_SVH

// Word addresses
`define ADDR_CTRL      4'h0
`define ADDR_ALARM     4'h1
`define ADDR_TRIP      4'h2
`define ADDR_RATED     4'h3
`define ADDR_BASE      4'h4
`define ADDR_UNLOCK    4'h5
`define ADDR_AMBIENT   4'h6
`define ADDR_STARTUP   4'h7
`define ADDR_LOAD      4'h8
`define ADDR_TCONST    4'h9
`define ADDR_PULSE     4'hA
`define ADDR_TEMP      4'hB
`define ADDR_STATUS    4'hC

// Control fields and mode codes
`define CTRL_MODE_MSB  1
`define CTRL_SENS_BIT  2
`define MODE_OFF       2'h0
`define MODE_PULSED    2'h1
`define MODE_LOCKED    2'h2

// Reset values
`define RST_ALARM      8'h50
`define RST_TRIP       8'h64
`define RST_RATED      8'h64
`define RST_BASE       8'h19
`define RST_UNLOCK     8'h3C
`define RST_AMBIENT    8'h19
`define RST_STARTUP    8'h00
`define RST_LOAD       8'h64
`define RST_TCONST     10'h00A
`define RST_PULSE      16'h0064

// Accepted setting ranges
`define LIM_TEMP_MIN   16'h003C
`define LIM_TEMP_MAX   16'h00C8
`define LIM_ZERO       16'h0000
`define LIM_LOW_MAX    16'h0028
`define LIM_UNL_MIN    16'h0014
`define LIM_START_MAX  16'h003C
`define LIM_LOAD_MIN   16'h0014
`define LIM_LOAD_MAX   16'h0096
`define LIM_TC_MIN     16'h0001
`define LIM_TC_MAX     16'h03E7
`define LIM_PULSE_MIN  16'h0001
`define LIM_PULSE_MAX  16'hFFFF

// Arithmetic constants
`define PCT_DIV        8'h64
`define SAMPLE_RATE_HZ 16'h03E8
`define SEC_PER_MIN    8'h3C
`define FRAC_BITS      32
`define TEMP_FRAC      4
`define DIV_W          72
`define DIV_CNT_INIT   7'h48

`endif

// File: common/line_thermal_pkg.sv
/*
 Types shared by the line thermal replica.
 Assumes nothing of its surroundings.
*/
package line_thermal_pkg;
    typedef enum logic [2:0] {
        ST_IDLE, ST_LOAD_STEP, ST_DIV_STEP, ST_APPLY, ST_DIV_TEMP, ST_DECIDE
    } calc_state_e;
endpackage

// File: sim/current_source.sv
/*
 Phase current source: one sample strobe every PERIOD clocks, square-wave samples.
 Assumes the bench sets the amplitudes; the strobe starts after reset release.
*/
`timescale 1ns/1ps

module current_source #(
    parameter int PERIOD = 250
) (
    // Clock and reset
    input  wire logic               core_clk,
    input  wire logic               rst_n,
    // Amplitudes from the bench
    input  wire logic signed [15:0] amp1,
    input  wire logic signed [15:0] amp2,
    input  wire logic signed [15:0] amp3,
    // Samples towards the block
    output logic                    sample_valid,
    output logic signed [15:0]      s1,
    output logic signed [15:0]      s2,
    output logic signed [15:0]      s3
);
    int   cnt;
    logic pol;
    logic hit;

    assign hit = (cnt == PERIOD - 1);

    // Sign alternates per sample, so the RMS equals the amplitude; lines are
    // garbled between strobes so a stale sample is never taken for a new one
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cnt <= 0;
            pol <= 1'b0;
            sample_valid <= 1'b0;
            {s1, s2, s3} <= '0;
        end else begin
            cnt <= hit ? 0 : cnt + 1;
            sample_valid <= hit;
            pol <= hit ? !pol : pol;
            s1 <= hit ? (pol ? -amp1 : amp1) : ~s1;
            s2 <= hit ? (pol ? -amp2 : amp2) : ~s2;
            s3 <= hit ? (pol ? -amp3 : amp3) : ~s3;
        end
    end
endmodule // current_source

// File: sim/tb_top.sv
/*
 Bench of the line thermal replica: register tasks, one task per scenario, verdict.
 Assumes the current source model supplies the sample strobe.
*/
`timescale 1ns/1ps
`include "line_thermal_regs.svh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin error_cnt++; \
    $display("[FAIL] %s expected %0h seen %0h", n, e, g); end end

module tb_top;
    logic               core_clk, rst_n, wr_en, rd_en, disable_in, heat_reset_in;
    logic               sample_valid, alarm_out, general_trip_out, reclose_block_out;
    logic        [3:0]  addr;
    logic        [15:0] wr_data, rd_data, calc_temperature_value, rd_v;
    logic signed [15:0] amp1, amp2, amp3, s1, s2, s3;
    logic signed [7:0]  sens;
    int                 error_cnt, checked, cyc, n;

    // Free-running clock, 100 ns period
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    line_thermal_fn dut_u (.core_clk(core_clk), .rst_n(rst_n), .addr(addr),
        .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .sample_valid(sample_valid), .phase1_current(s1), .phase2_current(s2),
        .phase3_current(s3), .ambient_sensor_temp(sens), .disable_in(disable_in),
        .heat_reset_in(heat_reset_in), .alarm_out(alarm_out),
        .general_trip_out(general_trip_out), .reclose_block_out(reclose_block_out),
        .calc_temperature_value(calc_temperature_value));
    current_source src_u (.core_clk(core_clk), .rst_n(rst_n), .amp1(amp1), .amp2(amp2),
        .amp3(amp3), .sample_valid(sample_valid), .s1(s1), .s2(s2), .s3(s3));

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge core_clk);
        wr_en <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a);
        @(posedge core_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge core_clk);
        rd_en <= 1'b0;
        #1 rd_v = rd_data;
    endtask

    // Wait k calculation steps plus margin for the outputs to settle
    task automatic steps(input int k);
        repeat (k) @(posedge core_clk iff sample_valid);
        repeat (160) @(posedge core_clk);
    endtask

    task automatic heat(input logic [15:0] pct);
        wr(`ADDR_STARTUP, pct);
        heat_reset_in <= 1'b1;
        repeat (3) @(posedge core_clk);
        heat_reset_in <= 1'b0;
        steps(1);
    endtask

    task automatic outs(input logic [2:0] e);
        `CHK("alarm trip block", e, {alarm_out, general_trip_out, reclose_block_out})
    endtask

    task automatic t_regs;
        logic [15:0] exp_v [10] = '{`RST_ALARM, `RST_TRIP, `RST_RATED, `RST_BASE,
            `RST_UNLOCK, `RST_AMBIENT, `RST_STARTUP, `RST_LOAD, `RST_TCONST, `RST_PULSE};
        for (int i = 0; i < 10; i++) begin
            rd(4'(i + 1));
            `CHK("reset value", exp_v[i], rd_v)
        end
        rd(`ADDR_CTRL);
        `CHK("control default", 16'h0001, rd_v)
        wr(`ADDR_TRIP, 16'h00FA);
        rd(`ADDR_TRIP);
        `CHK("trip upper clamp", 16'h00C8, rd_v)
        wr(`ADDR_ALARM, 16'h0014);
        rd(`ADDR_ALARM);
        `CHK("alarm lower clamp", 16'h003C, rd_v)
        wr(`ADDR_ALARM, `RST_ALARM);
        wr(`ADDR_TRIP, `RST_TRIP);
        wr(`ADDR_TEMP, 16'h1234);
        rd(4'hE);
        `CHK("unmapped read", 16'h0000, rd_v)
    endtask

    task automatic t_ambient;
        steps(1);
        `CHK("fixed ambient", 16'h0190, calc_temperature_value)
        rd(`ADDR_TEMP);
        `CHK("temperature read", 16'h0190, rd_v)
        wr(`ADDR_CTRL, 16'h0005);
        steps(1);
        `CHK("sensor ambient", 16'h01E0, calc_temperature_value)
        wr(`ADDR_CTRL, 16'h0001);
    endtask

    // Startup 60 % of a 200 degree rise gives 145 degrees total
    task automatic t_locked;
        wr(`ADDR_CTRL, {14'h0, `MODE_LOCKED});
        wr(`ADDR_RATED, 16'h00C8);
        wr(`ADDR_BASE, 16'h0000);
        heat(16'h003C);
        outs(3'b111);
        rd(`ADDR_STATUS);
        `CHK("status flags", 16'h003F, rd_v)
        wr(`ADDR_TRIP, 16'h00C8);
        steps(1);
        outs(3'b111);
        heat(16'h0000);
        outs(3'b000);
        wr(`ADDR_TRIP, `RST_TRIP);
    endtask

    task automatic t_block;
        heat(16'h003C);
        @(posedge core_clk);
        disable_in <= 1'b1;
        repeat (3) @(posedge core_clk);
        outs(3'b000);
        steps(1);
        outs(3'b000);
        disable_in <= 1'b0;
        steps(1);
        outs(3'b111);
        wr(`ADDR_CTRL, {14'h0, `MODE_OFF});
        steps(1);
        outs(3'b000);
    endtask

    task automatic t_pulsed;
        wr(`ADDR_CTRL, {14'h0, `MODE_PULSED});
        wr(`ADDR_PULSE, 16'h0003);
        heat(16'h0000);
        outs(3'b000);
        heat(16'h003C);
        outs(3'b111);
        n = 0;
        for (int i = 0; i < 3000 && general_trip_out === 1'b1; i++) begin
            @(posedge core_clk);
            n += int'(sample_valid === 1'b1);
        end
        // Three more strobes pass while a three-step pulse stands
        `CHK("pulse steps", 32'h3, n)
        outs(3'b101);
        steps(1);
        outs(3'b101);
        heat(16'h0000);
        heat(16'h003C);
        outs(3'b111);
        heat(16'h0000);
    endtask

    // Phase 2 dominates; the rise must show above ambient yet stay below trip
    task automatic t_heat;
        amp1 <= 16'sh1000;
        amp2 <= 16'sh7000;
        amp3 <= 16'sh0800;
        steps(40);
        `CHK("heated", 1'b1, calc_temperature_value > 16'h0190)
        outs(3'b000);
    endtask

    task automatic final_report;
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Hang guard, well above the roughly 15000 cycles the scenarios need
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 80000) begin
            error_cnt++;
            final_report();
        end
    end

    // Main sequence
    initial begin
        {rst_n, wr_en, rd_en, disable_in, heat_reset_in, addr, wr_data} = '0;
        {amp1, amp2, amp3} = '0;
        sens = 8'sh1E;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        t_regs();
        t_ambient();
        t_locked();
        t_block();
        t_pulsed();
        t_heat();
        final_report();
    end
endmodule // tb_top
